/* wkt_timer.sv */
// Purpose: wake-up timer with trim and card detect launch, avalon-mm register slave
// Assumes: lfo_in is asynchronous; detection engine and timer 3 lie outside
// Notes:   one packed state struct, one always_comb, one always_ff
//
// Functional notes
// [R01] start event loads the 16-bit counter from the two reload bytes.
// [R02] reload byte writes affect only the next start event.
// [R03] control bit 7 reads back the live running state.
// [R04] a control write changes the running bit only when it also sets strobe bit 6.
// [R05] bit 5 set: each underflow launches an oscillator trimming procedure.
// [R06] software configures a trim timer and avoids timer 3 with detect on.
// [R07] bit 4 set: each underflow starts a card detection sequence.
// [R08] card found: raise interrupt and stay active when enabled.
// [R09] no card: return to power-down when enabled.
// [R10] after detection the countdown restarts immediately.
// [R11] field stays on for the timer 3 window during detection.
// [R12] bit 3 set reloads at zero; clear stops at zero.
// [R13] every underflow sets the expiry interrupt flag.
// [R14] bit 2 set: underflow wakes the chip from power-down.
// [R15] software sets wake bit to return to power-down after procedures.
// [R16] bits 1:0 choose tick: oscillator, /8, /16, /32.
// [R17] two read-only bytes return the live counter high and low.
// [R18] host avoids reading timer 3 low byte during reception.
// [R19] decrement once per tick while running; reaching zero is underflow; hold when stopped.
//
// The implementer's own choice: the Avalon-MM slave port.
module wkt_timer
(
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  input  wire logic [9:0]  address_in,
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [31:0] writedata_in,
  input  wire logic [3:0]  byteenable_in,
  output logic [31:0]      readdata_out,
  output logic             waitrequest_out,
  output logic             readdatavalid_out,
  input  wire logic        lfo_in,
  input  wire logic [7:0]  timer3_count_low_in,
  input  wire logic        timer3_window_in,
  input  wire logic        card_result_in,
  input  wire logic        card_present_in,
  input  wire logic        power_down_req_in,
  output logic             irq_out,
  output logic             wake_out,
  output logic             trim_start_out,
  output logic             detect_start_out,
  output logic             field_on_out,
  output logic             power_down_out,
  output logic             timer_active_flag_out
);

  wkt_pkg::wkt_state_t s_q;
  wkt_pkg::wkt_state_t s_d;

  logic        lfo_rise;
  logic        tick;
  logic        underflow;
  logic [4:0]  div_max;
  logic [7:0]  reg_idx;
  logic        access_ok;
  logic        wr_acc;
  logic        rd_acc;
  logic [7:0]  ctl_rd;
  logic [7:0]  rd_byte;
  logic [7:0]  wdat;
  logic        card_done;
  logic        running;
  logic [2:0]  irq_set;
  logic        status_clr;

  always_comb
  begin
    s_d = s_q;
    s_d.wake_pulse = 1'b0;
    s_d.trim_pulse = 1'b0;
    s_d.detect_pulse = 1'b0;
    s_d.bus.readdatavalid = 1'b0;
    irq_set = 3'h0;
    status_clr = 1'b0;

    // synchronisers: first stage is read only by the second
    s_d.lfo_sync = {s_q.lfo_sync[0], lfo_in};
    s_d.lfo_prev = s_q.lfo_sync[1];
    s_d.cres_sync = {s_q.cres_sync[0], card_result_in};
    s_d.cpres_sync = {s_q.cpres_sync[0], card_present_in};
    lfo_rise = s_q.lfo_sync[1] & ~s_q.lfo_prev;
    card_done = s_q.cres_sync[1];

    case (s_q.cfg.tick_sel) // [R16]
      2'b01:   div_max = wkt_pkg::DIV_BY_8;
      2'b10:   div_max = wkt_pkg::DIV_BY_16;
      2'b11:   div_max = wkt_pkg::DIV_BY_32;
      default: div_max = 5'h00;
    endcase

    running = (s_q.phase != wkt_pkg::WKT_IDLE);
    tick = 1'b0;
    if (lfo_rise)
    begin
      if (s_q.prescale >= div_max)
      begin
        s_d.prescale = 5'h00;
        tick = 1'b1; // [R16]
      end
      else
      begin
        s_d.prescale = s_q.prescale + 5'h01;
      end
    end

    underflow = 1'b0;
    case (s_q.phase)
      wkt_pkg::WKT_COUNT:
      begin
        if (tick)
        begin
          if (s_q.count == 16'h0000 || s_q.count == 16'h0001)
          begin
            underflow = 1'b1; // [R19]
            s_d.count = 16'h0000;
          end
          else
          begin
            s_d.count = s_q.count - 16'h0001; // [R19]
          end
        end
      end
      wkt_pkg::WKT_DETECT:
      begin
        s_d.field_on = timer3_window_in; // [R11]
        if (card_done)
        begin
          s_d.field_on = 1'b0;
          s_d.count = s_q.reload; // [R10] [R01]
          s_d.phase = wkt_pkg::WKT_COUNT;
          if (s_q.cpres_sync[1])
          begin
            irq_set[wkt_pkg::IRQ_CARD_BIT] = 1'b1; // [R08]
            if (s_q.detect_ctrl[wkt_pkg::DCT_STAY_BIT])
            begin
              s_d.powered_down = 1'b0; // [R08]
            end
          end
          else if (s_q.detect_ctrl[wkt_pkg::DCT_SLEEP_BIT] && s_q.cfg.wake)
          begin
            s_d.powered_down = 1'b1; // [R09]
          end
        end
      end
      default: ;
    endcase

    if (underflow)
    begin
      irq_set[wkt_pkg::IRQ_EXPIRY_BIT] = 1'b1; // [R13]
      if (s_q.cfg.wake)
      begin
        s_d.wake_pulse = 1'b1; // [R14]
        s_d.powered_down = 1'b0; // [R14]
      end
      if (s_q.cfg.trim)
      begin
        s_d.trim_pulse = 1'b1; // [R05]
        irq_set[wkt_pkg::IRQ_TRIM_BIT] = 1'b1;
      end
      if (s_q.cfg.detect)
      begin
        s_d.detect_pulse = 1'b1; // [R07]
        s_d.field_on = timer3_window_in; // [R11]
        s_d.phase = wkt_pkg::WKT_DETECT;
      end
      else if (s_q.cfg.reload)
      begin
        s_d.count = s_q.reload; // [R12] [R01]
      end
      else
      begin
        s_d.phase = wkt_pkg::WKT_IDLE; // [R12]
      end
    end

    if (power_down_req_in)
    begin
      s_d.powered_down = 1'b1;
    end

    // bus slave: one wait cycle, answer on the second
    reg_idx = address_in[9:2];
    wdat = writedata_in[7:0];
    access_ok = (read_in | write_in) & s_q.bus.waitrequest & ~s_q.busy;
    // a write lands at the edge where the master sees waitrequest low
    wr_acc = write_in & ~s_q.bus.waitrequest & byteenable_in[0];
    rd_acc = access_ok & read_in;
    s_d.busy = access_ok;
    s_d.bus.waitrequest = ~((read_in | write_in) & s_q.bus.waitrequest & ~s_q.busy);

    ctl_rd = {running, 1'b0, s_q.cfg.trim, s_q.cfg.detect, s_q.cfg.reload,
              s_q.cfg.wake, s_q.cfg.tick_sel}; // [R03]
    case (reg_idx)
      wkt_pkg::IDX_T3_COUNT_LOW: rd_byte = timer3_count_low_in; // [R18]
      wkt_pkg::IDX_CONTROL:      rd_byte = ctl_rd;
      wkt_pkg::IDX_RELOAD_HIGH:  rd_byte = s_q.reload[15:8];
      wkt_pkg::IDX_RELOAD_LOW:   rd_byte = s_q.reload[7:0];
      wkt_pkg::IDX_COUNT_HIGH:   rd_byte = s_q.count[15:8]; // [R17]
      wkt_pkg::IDX_COUNT_LOW:    rd_byte = s_q.count[7:0]; // [R17]
      wkt_pkg::IDX_IRQ_STATUS:   rd_byte = {5'h00, s_q.irq_status};
      wkt_pkg::IDX_IRQ_MASK:     rd_byte = {5'h00, s_q.irq_mask};
      wkt_pkg::IDX_DETECT_CTRL:  rd_byte = {6'h00, s_q.detect_ctrl};
      wkt_pkg::IDX_POWER_STATUS: rd_byte = {7'h00, s_q.powered_down};
      default:                   rd_byte = 8'h00;
    endcase

    if (rd_acc)
    begin
      s_d.bus.readdata = {24'h00_0000, rd_byte};
      s_d.bus.readdatavalid = 1'b1;
      if (reg_idx == wkt_pkg::IDX_IRQ_STATUS)
      begin
        status_clr = 1'b1;
      end
    end

    if (wr_acc)
    begin
      case (reg_idx)
        wkt_pkg::IDX_CONTROL:
        begin
          s_d.cfg.trim = wdat[wkt_pkg::CTL_TRIM_BIT];
          s_d.cfg.detect = wdat[wkt_pkg::CTL_DETECT_BIT];
          s_d.cfg.reload = wdat[wkt_pkg::CTL_RELOAD_BIT];
          s_d.cfg.wake = wdat[wkt_pkg::CTL_WAKE_BIT];
          s_d.cfg.tick_sel = wdat[wkt_pkg::CTL_TICK_LSB +: 2];
          if (wdat[wkt_pkg::CTL_STROBE_BIT]) // [R04]
          begin
            if (wdat[wkt_pkg::CTL_ACTIVE_BIT])
            begin
              s_d.phase = wkt_pkg::WKT_COUNT;
              s_d.count = s_q.reload; // [R01]
              s_d.prescale = 5'h00;
            end
            else
            begin
              s_d.phase = wkt_pkg::WKT_IDLE;
              s_d.field_on = 1'b0;
            end
          end
        end
        wkt_pkg::IDX_RELOAD_HIGH: s_d.reload[15:8] = wdat; // [R02]
        wkt_pkg::IDX_RELOAD_LOW:  s_d.reload[7:0] = wdat; // [R02]
        wkt_pkg::IDX_IRQ_MASK:    s_d.irq_mask = wdat[2:0];
        wkt_pkg::IDX_DETECT_CTRL: s_d.detect_ctrl = wdat[1:0];
        default: ;
      endcase
    end

    // read clears, but an event in the same cycle stays set
    s_d.irq_status = (status_clr ? 3'h0 : s_q.irq_status) | irq_set;
    s_d.irq = |(s_d.irq_status & s_d.irq_mask);
    s_d.active = (s_d.phase != wkt_pkg::WKT_IDLE); // [R03]
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      s_q <= '0;
      s_q.phase <= wkt_pkg::WKT_IDLE;
      s_q.cfg <= wkt_pkg::RST_CONFIG;
      s_q.reload <= wkt_pkg::RST_RELOAD;
      s_q.irq_mask <= wkt_pkg::RST_IRQ_MASK;
      s_q.detect_ctrl <= wkt_pkg::RST_DETECT;
      s_q.bus.waitrequest <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign readdata_out = s_q.bus.readdata;
  assign waitrequest_out = s_q.bus.waitrequest;
  assign readdatavalid_out = s_q.bus.readdatavalid;
  assign irq_out = s_q.irq;
  assign wake_out = s_q.wake_pulse;
  assign trim_start_out = s_q.trim_pulse;
  assign detect_start_out = s_q.detect_pulse;
  assign field_on_out = s_q.field_on;
  assign power_down_out = s_q.powered_down;
  assign timer_active_flag_out = s_q.active;

endmodule : wkt_timer

/* wkt_pkg.sv */
// Purpose: constants and carrier types for the wake-up timer block
// Assumes: avalon-mm register bus with 32-bit data, one register per word
// Notes:   printed offsets are register indices; byte address is index times four
package wkt_pkg;

  // register indices
  localparam logic [7:0] IDX_T3_COUNT_LOW   = 8'h22;
  localparam logic [7:0] IDX_CONTROL        = 8'h23;
  localparam logic [7:0] IDX_RELOAD_HIGH    = 8'h24;
  localparam logic [7:0] IDX_RELOAD_LOW     = 8'h25;
  localparam logic [7:0] IDX_COUNT_HIGH     = 8'h26;
  localparam logic [7:0] IDX_COUNT_LOW      = 8'h27;
  localparam logic [7:0] IDX_IRQ_STATUS     = 8'h30;
  localparam logic [7:0] IDX_IRQ_MASK       = 8'h31;
  localparam logic [7:0] IDX_DETECT_CTRL    = 8'h32;
  localparam logic [7:0] IDX_POWER_STATUS   = 8'h33;

  // control byte fields
  localparam int CTL_ACTIVE_BIT  = 7;
  localparam int CTL_STROBE_BIT  = 6;
  localparam int CTL_TRIM_BIT    = 5;
  localparam int CTL_DETECT_BIT  = 4;
  localparam int CTL_RELOAD_BIT  = 3;
  localparam int CTL_WAKE_BIT    = 2;
  localparam int CTL_TICK_LSB    = 0;

  // interrupt status fields
  localparam int IRQ_EXPIRY_BIT  = 0;
  localparam int IRQ_CARD_BIT    = 1;
  localparam int IRQ_TRIM_BIT    = 2;

  // detect control fields
  localparam int DCT_STAY_BIT    = 0;
  localparam int DCT_SLEEP_BIT   = 1;

  // reset values
  localparam logic [15:0] RST_RELOAD   = 16'h0000;
  localparam logic [5:0]  RST_CONFIG   = 6'h00;
  localparam logic [2:0]  RST_IRQ_MASK = 3'h0;
  localparam logic [1:0]  RST_DETECT   = 2'h0;

  // tick divider ratios
  localparam logic [4:0] DIV_BY_8  = 5'h07;
  localparam logic [4:0] DIV_BY_16 = 5'h0f;
  localparam logic [4:0] DIV_BY_32 = 5'h1f;

  typedef enum logic [1:0]
  {
    WKT_IDLE   = 2'b00,
    WKT_COUNT  = 2'b01,
    WKT_DETECT = 2'b10
  } wkt_phase_t;

  typedef struct packed
  {
    logic        trim;
    logic        detect;
    logic        reload;
    logic        wake;
    logic [1:0]  tick_sel;
  } wkt_config_t;

  typedef struct packed
  {
    logic [31:0] readdata;
    logic        readdatavalid;
    logic        waitrequest;
  } wkt_bus_resp_t;

  typedef struct packed
  {
    wkt_phase_t     phase;
    wkt_config_t    cfg;
    logic [15:0]    reload;
    logic [15:0]    count;
    logic [4:0]     prescale;
    logic [2:0]     irq_status;
    logic [2:0]     irq_mask;
    logic [1:0]     detect_ctrl;
    logic           powered_down;
    logic           irq;
    logic           wake_pulse;
    logic           trim_pulse;
    logic           detect_pulse;
    logic           field_on;
    logic           busy;
    logic           active;
    logic [1:0]     lfo_sync;
    logic           lfo_prev;
    logic [1:0]     cres_sync;
    logic [1:0]     cpres_sync;
    wkt_bus_resp_t  bus;
  } wkt_state_t;

endpackage : wkt_pkg

/* wkt_timer_asserts.sv */
// Purpose: port-level checks of the wake-up timer
// Assumes: one clock, synchronous active-high reset
// Notes:   attached to every wkt_timer by the bind below
module wkt_timer_chk
(
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic waitrequest_out,
  input wire logic readdatavalid_out,
  input wire logic timer3_window_in,
  input wire logic irq_out,
  input wire logic wake_out,
  input wire logic trim_start_out,
  input wire logic detect_start_out,
  input wire logic field_on_out,
  input wire logic timer_active_flag_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  rdv_pair_a: assert property (readdatavalid_out |-> !waitrequest_out && read_in) else $error("stray read data");
  wait_one_a: assert property (!waitrequest_out |=> waitrequest_out) else $error("wait low too long");
  wake_pulse_a: assert property (wake_out |=> !wake_out) else $error("wake pulse long");
  trim_pulse_a: assert property (trim_start_out |=> !trim_start_out) else $error("trim pulse long");
  det_pulse_a: assert property (detect_start_out |=> !detect_start_out) else $error("detect pulse long");
  field_gate_a: assert property (field_on_out |-> $past(timer3_window_in)) else $error("field without window");
  run_start_a: assert property ($rose(timer_active_flag_out) |-> $past(write_in && !waitrequest_out))
    else $error("run without write");
  det_active_a: assert property (detect_start_out |-> timer_active_flag_out) else $error("detect while idle");
  wake_c: cover property (wake_out);
  det_c: cover property (detect_start_out);
  irq_c: cover property (irq_out);
endmodule : wkt_timer_chk

bind wkt_timer wkt_timer_chk wkt_timer_chk_i (.mclk_in, .reset_in, .read_in, .write_in, .waitrequest_out,
  .readdatavalid_out, .timer3_window_in, .irq_out, .wake_out, .trim_start_out, .detect_start_out,
  .field_on_out, .timer_active_flag_out);

/* wkt_tb.sv */
// Purpose: self-checking bench of the wake-up timer
// Assumes: avalon master waits on waitrequest, lfo edges paced slowly
// Notes:   scenarios run in order and share the bus and lfo tasks
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_in = 0, reset_in = 1, read_in = 0, write_in = 0, lfo_in = 0;
  logic [9:0]  address_in = 10'h000;
  logic [31:0] writedata_in = 32'h0000_0000, readdata_out;
  logic [3:0]  byteenable_in = 4'h1;
  logic        win = 0, res = 0, pres = 0, pdr = 0;
  logic        waitrequest_out, readdatavalid_out, irq_out, wake_out, trim_start_out;
  logic        detect_start_out, field_on_out, power_down_out, timer_active_flag_out;
  logic [2:0]  seen = 3'h0;
  logic [7:0]  r;
  int          bad_count = 0, checks = 0;
  always #5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) seen <= seen | {detect_start_out, trim_start_out, wake_out};
  wkt_timer wkt_timer_i (.mclk_in, .reset_in, .address_in, .read_in, .write_in, .writedata_in, .byteenable_in,
    .readdata_out, .waitrequest_out, .readdatavalid_out, .lfo_in, .timer3_count_low_in(8'h5a),
    .timer3_window_in(win), .card_result_in(res), .card_present_in(pres), .power_down_req_in(pdr), .irq_out,
    .wake_out, .trim_start_out, .detect_start_out, .field_on_out, .power_down_out, .timer_active_flag_out);
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge mclk_in);
    write_in <= wr;
    read_in <= !wr;
    address_in <= {idx, 2'b00};
    writedata_in <= {24'h00_0000, wd};
    do @(posedge mclk_in); while (waitrequest_out !== 1'b0 && ++n < 50);
    if (waitrequest_out !== 1'b0)
    begin
      bad_count++;
      $display("Error at %0t waitrequest got %h expected %h", $time, waitrequest_out, 1'b0);
      final_report();
    end
    r = readdata_out[7:0];
    write_in <= 1'b0;
    read_in <= 1'b0;
  endtask : bus
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(r, exp);
  endtask : rd
  task automatic low_freq_oscillator(input int k);
    repeat (k)
    begin
      @(posedge mclk_in) lfo_in <= 1'b1;
      repeat (3) @(posedge mclk_in);
      lfo_in <= 1'b0;
      repeat (3) @(posedge mclk_in);
    end
    repeat (4) @(posedge mclk_in);
  endtask : low_freq_oscillator
  task automatic t_regs;
    rd(8'h23, 8'h00);
    bus(1'b1, 8'h24, 8'h12);
    rd(8'h24, 8'h12);
    bus(1'b1, 8'h26, 8'h55);
    rd(8'h26, 8'h00);
    rd(8'h22, 8'h5a);
    rd(8'h40, 8'h00);
    bus(1'b1, 8'h23, 8'h80);
    rd(8'h23, 8'h00);
    $display("test regs done");
  endtask : t_regs
  task automatic t_count;
    bus(1'b1, 8'h24, 8'h00);
    bus(1'b1, 8'h25, 8'h05);
    bus(1'b1, 8'h31, 8'h01);
    bus(1'b1, 8'h23, 8'hc0);
    rd(8'h23, 8'h80);
    bus(1'b1, 8'h25, 8'h40);
    low_freq_oscillator(2);
    rd(8'h27, 8'h03);
    bus(1'b1, 8'h23, 8'h00);
    rd(8'h23, 8'h80);
    low_freq_oscillator(3);
    rd(8'h27, 8'h00);
    rd(8'h23, 8'h00);
    chk(irq_out, 1'b1);
    rd(8'h30, 8'h01);
    rd(8'h30, 8'h00);
    chk(irq_out, 1'b0);
    bus(1'b1, 8'h25, 8'h02);
    bus(1'b1, 8'h23, 8'hc8);
    low_freq_oscillator(2);
    rd(8'h27, 8'h02);
    rd(8'h23, 8'h88);
    low_freq_oscillator(1);
    rd(8'h27, 8'h01);
    bus(1'b1, 8'h23, 8'h40);
    rd(8'h30, 8'h01);
    $display("test count done");
  endtask : t_count
  task automatic t_div;
    for (int s = 0; s < 4; s++)
    begin
      bus(1'b1, 8'h25, 8'h03);
      bus(1'b1, 8'h23, 8'hc0 | 8'(s));
      low_freq_oscillator(s == 0 ? 2 : 2 << (s + 2));
      rd(8'h27, 8'h01);
      bus(1'b1, 8'h23, 8'h40);
    end
    $display("test divider done");
  endtask : t_div
  task automatic t_det;
    bus(1'b1, 8'h32, 8'h03);
    bus(1'b1, 8'h31, 8'h02);
    bus(1'b1, 8'h25, 8'h02);
    @(posedge mclk_in) pdr <= 1'b1;
    @(posedge mclk_in) pdr <= 1'b0;
    repeat (2) @(posedge mclk_in);
    chk(power_down_out, 1'b1);
    bus(1'b1, 8'h23, 8'hfc);
    low_freq_oscillator(2);
    chk(seen, 3'h7);
    chk(power_down_out, 1'b0);
    @(posedge mclk_in) win <= 1'b1;
    repeat (3) @(posedge mclk_in);
    chk(field_on_out, 1'b1);
    win <= 1'b0;
    res <= 1'b1;
    repeat (4) @(posedge mclk_in);
    res <= 1'b0;
    repeat (4) @(posedge mclk_in);
    chk(power_down_out, 1'b1);
    rd(8'h27, 8'h02);
    chk(timer_active_flag_out, 1'b1);
    low_freq_oscillator(2);
    @(posedge mclk_in) pdr <= 1'b1;
    @(posedge mclk_in) pdr <= 1'b0;
    repeat (2) @(posedge mclk_in);
    chk(power_down_out, 1'b1);
    pres <= 1'b1;
    res <= 1'b1;
    repeat (4) @(posedge mclk_in);
    res <= 1'b0;
    repeat (4) @(posedge mclk_in);
    chk(irq_out, 1'b1);
    chk(power_down_out, 1'b0);
    bus(1'b0, 8'h30, 8'h00);
    chk(r & 8'h02, 8'h02);
    $display("test detect done");
  endtask : t_det
  initial
  begin
    repeat (10) @(posedge mclk_in);
    reset_in <= 1'b0;
    t_regs();
    t_count();
    t_div();
    t_det();
    final_report();
  end
endmodule : testbench
